// ===== rtl/aatc_regs.svh
`ifndef AATC_REGS_SVH
`define AATC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define AATC_OFS_CFG        8'h18
`define AATC_OFS_CTRL       8'h1C
`define AATC_OFS_STATUS     8'h20
`define AATC_OFS_OUT        8'h24

// ----------------------------------------
// Sensor configuration fields
// ----------------------------------------
`define AATC_CFG_TRIG_MODE  7
`define AATC_CFG_WAKE_WT    6
`define AATC_CFG_WAKE_OT    5
`define AATC_CFG_WAKE_OR    4
`define AATC_CFG_PULSE_SEL  3
`define AATC_CFG_PIN2_TRIG  2
`define AATC_CFG_DRV_TYPE   1
`define AATC_CFG_POLARITY   0
`define AATC_CFG_RESET      8'h01

// ----------------------------------------
// Acquisition control fields
// ----------------------------------------
`define AATC_CTRL_DEC_LSB   0
`define AATC_CTRL_PWR_LSB   4
`define AATC_CTRL_BUF_LSB   6
`define AATC_CTRL_RESET     8'h00

// ----------------------------------------
// Decimation and timing
// ----------------------------------------
`define AATC_DEC_LOG2_MAX   4'd12
`define AATC_CLK_HZ         20000000
`define AATC_ACQ_TIME_NS    312500
`define AATC_GAP_TIME_US    500
`define AATC_PULSE_TIME_US  32
`define AATC_ACQ_CYCLES     ((`AATC_ACQ_TIME_NS * (`AATC_CLK_HZ / 1000000)) / 1000)
`define AATC_GAP_CYCLES     (`AATC_GAP_TIME_US * (`AATC_CLK_HZ / 1000000))
`define AATC_PULSE_CYCLES   (`AATC_PULSE_TIME_US * (`AATC_CLK_HZ / 1000000))

`endif

// ===== rtl/aatc_pkg.sv
package aatc_pkg;

  // ----------------------------------------
  // Operating modes and sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {PWR_LPM, PWR_HPM, PWR_FPM, PWR_FPM_ALT} aatc_pwr_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ} aatc_state_e;

  // ----------------------------------------
  // Register state of the top module
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  ctrl;
    aatc_state_e st;
    logic [12:0] cnt;
    logic [15:0] tmr;
    logic [15:0] gap;
    logic [15:0] pulse;
    logic [11:0] result;
    logic        drdy;
    logic        burst;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_s3;
    logic        boot_s1;
    logic        boot_s2;
    logic        sleep_q;
  } aatc_state_s;

  // ----------------------------------------
  // Accumulator state of the averager
  // ----------------------------------------
  typedef struct packed {
    logic signed [23:0] acc;
  } aatc_avg_s;

endpackage : aatc_pkg

// ===== rtl/aatc_avg.sv
`timescale 1ns/1ps
`include "aatc_regs.svh"

module aatc_avg
  import aatc_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Group control
  input  wire logic               clr,
  input  wire logic               add,
  input  wire logic signed [11:0] sample,
  input  wire logic        [3:0]  lg,
  // Mean of the group
  output logic signed      [11:0] avg
);

  aatc_avg_s r;
  aatc_avg_s next_r;

  // ----------------------------------------
  // Accumulate; the group's last sample goes straight into the mean
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    if (clr)
    begin
      next_r.acc = '0;
    end
    else if (add)
    begin
      next_r.acc = r.acc + 24'(sample);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Power-of-two group size, so the mean is an arithmetic shift
  // Meaningful only in the cycle of the group's last acquisition
  assign avg = 12'((r.acc + 24'(sample)) >>> lg);

endmodule : aatc_avg

// ===== rtl/aatc_top.sv
// How it works
// [R1] Flexible mode: code doubles count, 4096 cap
// [R2] High performance codes at top give 4096
// [R3] Eight-bit config register at 18h, reset 01h
// [R4] Single mode: one conversion per rising edge
// [R5] Burst mode: each edge runs full decimation
// [R6] Trigger mode matters only with pin trigger
// [R7] Data-ready only after result, buffer mode 00
// [R8] Low power fixes decimation at one
// [R9] Within-threshold event wakes when enabled
// [R10] Outside-threshold event wakes when enabled
// [R11] Orientation change wakes when enabled
// [R12] Level data-ready held until output read
// [R13] Pulse select gives 32 us pulse
// [R14] Pulse ORed with other pin interrupts
// [R15] Motion detection strap ignores pulse select
// [R16] Pin acts as trigger input, rising edge
// [R17] Host changes rate only in standby
// [R18] 500 us gap on wake/sleep change
// [R19] Counter cleared after each stored result
// [R20] Stored result is the group average
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "aatc_regs.svh"

module aatc_top
  import aatc_pkg::*;
#(
  parameter int ACQ_CYCLES   = `AATC_ACQ_CYCLES,
  parameter int GAP_CYCLES   = `AATC_GAP_CYCLES,
  parameter int PULSE_CYCLES = `AATC_PULSE_CYCLES
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shared interrupt / trigger pin
  input  wire logic        irq_pin_in,
  output logic             irq_pin_out,
  output logic             irq_pin_oe_n,
  input  wire logic        other_irq,
  // Boot strap pin, high selects motion detection
  input  wire logic        boot_strap_mode_pin,
  // Converter
  output logic             conv_start,
  input  wire logic [11:0] conv_data,
  // Results toward buffer
  output logic             buf_wr_valid,
  output logic      [11:0] buf_wr_data,
  // Rate and sleep logic
  input  wire logic        odr_tick,
  input  wire logic        sleep_mode,
  input  wire logic        evt_within_thr,
  input  wire logic        evt_outside_thr,
  input  wire logic        evt_orientation,
  output logic             wake_event
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ACQ_CYCLES < 1 || ACQ_CYCLES > 65535)
  begin : g_bad_acq
    $error("ACQ_CYCLES out of range");
  end
  if (GAP_CYCLES < 1 || GAP_CYCLES > 65535)
  begin : g_bad_gap
    $error("GAP_CYCLES out of range");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
  begin : g_bad_pulse
    $error("PULSE_CYCLES out of range");
  end

  localparam logic [15:0] ACQ_LAST   = 16'(ACQ_CYCLES - 1);
  localparam logic [15:0] GAP_LOAD   = 16'(GAP_CYCLES);
  localparam logic [15:0] PULSE_LOAD = 16'(PULSE_CYCLES);

  // ----------------------------------------
  // Decimation decode
  // ----------------------------------------
  // Log2 of the acquisitions per output sample
  function automatic logic [3:0] dec_log2(input logic [3:0] code, input aatc_pwr_e pwr);
    logic [3:0] lg;
    lg = (code > `AATC_DEC_LOG2_MAX) ? `AATC_DEC_LOG2_MAX : code; // R1 R2
    if (pwr == PWR_LPM)
    begin
      lg = 4'h0; // R8
    end
    return lg;
  endfunction : dec_log2

  aatc_state_s r;
  aatc_state_s next_r;

  logic        boot_md;
  logic        pin2_trig;
  logic        burst_mode;
  logic        pulse_eff;
  logic [3:0]  lg;
  logic [12:0] target;
  logic [1:0]  buf_mode;
  logic        trig_edge;
  logic        wr_en;
  logic        rd_en;
  logic        acq_done;
  logic        group_done;
  logic        store_out;
  logic        start_req;
  logic        irq_active;
  logic signed [11:0] avg;

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  // Strap in motion detection disables trigger and pulse options
  assign boot_md    = r.boot_s2;
  assign pin2_trig  = r.cfg[`AATC_CFG_PIN2_TRIG] & ~boot_md; // R16
  assign burst_mode = pin2_trig ? r.cfg[`AATC_CFG_TRIG_MODE] : 1'b1; // R6
  assign pulse_eff  = r.cfg[`AATC_CFG_PULSE_SEL] & ~boot_md; // R15
  assign lg         = dec_log2(r.ctrl[`AATC_CTRL_DEC_LSB +: 4],
                               aatc_pwr_e'(r.ctrl[`AATC_CTRL_PWR_LSB +: 2]));
  assign target     = 13'h0001 << lg; // R1
  assign buf_mode   = r.ctrl[`AATC_CTRL_BUF_LSB +: 2];

  // Rising edge seen only on synchronised copies
  assign trig_edge  = r.trig_s2 & ~r.trig_s3; // R16

  // ----------------------------------------
  // APB access decode
  // ----------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(paddr == `AATC_OFS_CFG || paddr == `AATC_OFS_CTRL
                   || paddr == `AATC_OFS_STATUS || paddr == `AATC_OFS_OUT);

  // Read mux of stored state
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `AATC_OFS_CFG:    prdata = {24'h00_0000, r.cfg}; // R3
      `AATC_OFS_CTRL:   prdata = {24'h00_0000, r.ctrl};
      `AATC_OFS_STATUS: prdata = {24'h00_0000, lg, boot_md, r.sleep_q,
                                  (r.st == ST_ACQ), r.drdy};
      `AATC_OFS_OUT:    prdata = {20'h0_0000, r.result};
      default:          prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Sequencer terms
  // ----------------------------------------
  assign acq_done   = (r.st == ST_ACQ) && (r.tmr == 16'h0000);
  assign group_done = acq_done && ((r.cnt + 13'h0001) == target);
  // Starts wait out the wake/sleep gap and any running burst
  assign start_req  = (r.gap == 16'h0000) && (r.st == ST_IDLE)
                      && (pin2_trig ? trig_edge : odr_tick); // R18
  assign store_out  = group_done && (buf_mode == 2'b00);

  // ----------------------------------------
  // Group averager
  // ----------------------------------------
  aatc_avg u_avg (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (group_done),
    .add     (acq_done),
    .sample  (conv_data),
    .lg      (lg),
    .avg     (avg)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    // Two-flop synchronisers for the pins
    next_r.trig_s1 = irq_pin_in;
    next_r.trig_s2 = r.trig_s1;
    next_r.trig_s3 = r.trig_s2;
    next_r.boot_s1 = boot_strap_mode_pin;
    next_r.boot_s2 = r.boot_s1;
    next_r.sleep_q = sleep_mode;

    // Register writes; rate fields are trusted to change in standby
    if (wr_en && paddr == `AATC_OFS_CFG)
    begin
      next_r.cfg = pwdata[7:0]; // R3
    end
    if (wr_en && paddr == `AATC_OFS_CTRL)
    begin
      next_r.ctrl = pwdata[7:0]; // R17
    end

    // Gap after a wake/sleep change
    if (sleep_mode != r.sleep_q)
    begin
      next_r.gap = GAP_LOAD; // R18
    end
    else if (r.gap != 16'h0000)
    begin
      next_r.gap = r.gap - 16'h0001;
    end

    // Acquisition sequencer
    case (r.st)
      ST_IDLE:
      begin
        if (start_req)
        begin
          next_r.st    = ST_ACQ;
          next_r.tmr   = ACQ_LAST;
          next_r.burst = burst_mode; // R4 R5
        end
      end
      ST_ACQ:
      begin
        if (r.tmr != 16'h0000)
        begin
          next_r.tmr = r.tmr - 16'h0001;
        end
        else if (group_done)
        begin
          next_r.cnt = 13'h0000; // R19
          next_r.st  = ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt + 13'h0001; // R4
          if (r.burst)
          begin
            next_r.tmr = ACQ_LAST; // R5
          end
          else
          begin
            next_r.st = ST_IDLE; // R4
          end
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase

    // Result capture, average of the group
    if (store_out)
    begin
      next_r.result = avg; // R20
    end

    // Data-ready: read clears, a new result wins
    if (rd_en && paddr == `AATC_OFS_OUT)
    begin
      next_r.drdy = 1'b0; // R12
    end
    if (store_out)
    begin
      next_r.drdy = 1'b1; // R7
    end

    // Pulse timer, retriggered per stored result
    if (store_out && pulse_eff)
    begin
      next_r.pulse = PULSE_LOAD; // R13
    end
    else if (r.pulse != 16'h0000)
    begin
      next_r.pulse = r.pulse - 16'h0001;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r      <= '0;
      r.cfg  <= `AATC_CFG_RESET; // R3
      r.ctrl <= `AATC_CTRL_RESET;
      r.st   <= ST_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Converter and buffer outputs
  // ----------------------------------------
  assign conv_start   = start_req || (acq_done && !group_done && r.burst);
  assign buf_wr_valid = group_done && (buf_mode != 2'b00);
  // Averager output folds in the last sample; valid only with buf_wr_valid
  assign buf_wr_data  = avg;

  // ----------------------------------------
  // Wake sources
  // ----------------------------------------
  assign wake_event = (evt_within_thr  & r.cfg[`AATC_CFG_WAKE_WT])  // R9
                    | (evt_outside_thr & r.cfg[`AATC_CFG_WAKE_OT])  // R10
                    | (evt_orientation & r.cfg[`AATC_CFG_WAKE_OR]); // R11

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  // Level follows the flag; pulse mode uses the timer instead
  assign irq_active = (pulse_eff ? (r.pulse != 16'h0000) : r.drdy) // R12 R13
                      | other_irq; // R14

  always_comb
  begin
    irq_pin_out  = irq_active ~^ r.cfg[`AATC_CFG_POLARITY]; // R13
    irq_pin_oe_n = 1'b0;
    if (pin2_trig)
    begin
      irq_pin_oe_n = 1'b1; // R16
    end
    else if (r.cfg[`AATC_CFG_DRV_TYPE] || boot_md)
    begin
      // Open drain: drive only the asserted level
      irq_pin_oe_n = ~irq_active;
    end
  end

endmodule : aatc_top

// ===== bench/aatc_properties.sv
`timescale 1ns/1ps
module aatc_checker #(
  parameter int ACQ_CYCLES   = 4,
  parameter int GAP_CYCLES   = 20,
  parameter int PULSE_CYCLES = 5
)
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe_n,
  input wire logic        other_irq,
  input wire logic        boot_strap_mode_pin,
  // Acquisition and wake
  input wire logic        conv_start,
  input wire logic        evt_within_thr,
  input wire logic        evt_outside_thr,
  input wire logic        evt_orientation,
  input wire logic        wake_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------
  // Shadow state
  // ------------
  logic [7:0]  cfg;
  logic [15:0] hi_cnt;
  wire acc    = psel & penable;
  wire asrt   = (irq_pin_out == cfg[0]);
  wire quiet  = !cfg[2] & !cfg[1] & !boot_strap_mode_pin & !other_irq;
  wire rd_out = acc & !pwrite & (paddr == 8'h24);
  // Config copy, follows writes taken on the bus
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg <= 8'h01;
    else if (acc && pwrite && paddr == 8'h18)
      cfg <= pwdata[7:0];
  // Length of the current asserted stretch; wide enough for the whole run
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_cnt <= 16'h0000;
    else
      hi_cnt <= asrt ? hi_cnt + 16'h0001 : 16'h0000;
  // ----------
  // Properties
  // ----------
  a_cfg_readback: assert property (acc && !pwrite && paddr == 8'h18 |-> prdata == {24'h0, cfg})
    else $error("config readback wrong");
  a_acq_spacing: assert property (conv_start |=> !conv_start [*3])
    else $error("acquisition too short");
  a_wake_within: assert property (evt_within_thr && cfg[6] |-> wake_event)
    else $error("within event lost");
  a_wake_outside: assert property (evt_outside_thr && cfg[5] |-> wake_event)
    else $error("outside event lost");
  a_wake_src_orientation: assert property (evt_orientation && cfg[4] |-> wake_event)
    else $error("orientation event lost");
  a_wake_none: assert property (!(evt_within_thr && cfg[6]) && !(evt_outside_thr && cfg[5])
    && !(evt_orientation && cfg[4]) |-> !wake_event)
    else $error("wake without enabled event");
  a_trig_input: assert property (!$past(boot_strap_mode_pin, 2)
    && !cfg[1] |-> irq_pin_oe_n == cfg[2])
    else $error("pin direction wrong");
  a_level_hold: assert property (!cfg[3] && quiet && $past(quiet) && $stable(cfg) && $past(asrt)
    && !$past(rd_out) |-> asrt)
    else $error("level dropped before read");
  a_pulse_width: assert property (cfg[3] && quiet && $stable(cfg) && $past(asrt) && !asrt
    |-> hi_cnt == PULSE_CYCLES)
    else $error("pulse width wrong");
  a_other_or: assert property (other_irq && $past(other_irq) && !cfg[2] && !cfg[1] |-> asrt)
    else $error("other interrupt not on pin");
  // Main scenarios reached
  c_burst: cover property (conv_start ##4 conv_start);
  c_pulse: cover property (cfg[3] && $past(asrt) && !asrt);
  c_wake: cover property (evt_within_thr && wake_event);
endmodule : aatc_checker

bind aatc_top aatc_checker #(
  .ACQ_CYCLES(ACQ_CYCLES), .GAP_CYCLES(GAP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) aatc_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .irq_pin_out,
  .irq_pin_oe_n, .other_irq, .boot_strap_mode_pin, .conv_start, .evt_within_thr,
  .evt_outside_thr, .evt_orientation, .wake_event
);

// ===== bench/aatc_host.sv
`timescale 1ns/1ps
module aatc_host
(
  // Clock
  input wire logic  pclk,
  // Device side
  input wire logic  conv_start,
  input wire logic  irq_pin_out,
  input wire logic  irq_pin_oe_n,
  output logic [11:0] conv_data,
  output logic      irq_pin_in,
  // Bench side
  input wire logic  trig_lvl
);
  // Host drives its trigger only while the device leaves the pin as input
  assign irq_pin_in = irq_pin_oe_n ? trig_lvl : irq_pin_out;
  // New sample per acquisition, held until the next one starts
  initial conv_data = 12'h000;
  always @(posedge pclk)
    if (conv_start === 1'b1)
      conv_data <= 12'($urandom);
endmodule : aatc_host

// ===== bench/accel_acq_trigger_config_tb.sv
`timescale 1ns/1ps
module accel_acq_trigger_config_tb;
  // -------
  // Signals
  // -------
  localparam int PUL = 5;
  localparam int GAP = 20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig = 0;
  logic [7:0]  paddr = 8'h00, v;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, irq_pin_in, irq_pin_out, irq_pin_oe_n;
  logic        other_irq = 0, boot_strap_mode_pin = 0, conv_start, buf_wr_valid, wake_event;
  logic        odr_tick = 0, sleep_mode = 0, evt_within_thr = 0, evt_outside_thr = 0;
  logic        evt_orientation = 0;
  logic [11:0] conv_data, buf_wr_data, bw_data;
  logic signed [11:0] samp_q[$];
  int          error_cnt = 0, n_tests = 0, n_conv = 0, bw_cnt = 0, hi, p, c;

  aatc_top #(.ACQ_CYCLES(4), .GAP_CYCLES(GAP), .PULSE_CYCLES(PUL)) aatc_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq_pin_in, .irq_pin_out, .irq_pin_oe_n, .other_irq, .boot_strap_mode_pin, .conv_start,
    .conv_data, .buf_wr_valid, .buf_wr_data, .odr_tick, .sleep_mode, .evt_within_thr,
    .evt_outside_thr, .evt_orientation, .wake_event);
  aatc_host aatc_host_inst (.pclk, .conv_start, .irq_pin_out, .irq_pin_oe_n, .conv_data,
    .irq_pin_in, .trig_lvl(trig));

  // Clock
  always #25 pclk = ~pclk;
  // Reference: every sample and every buffer write
  always @(posedge pclk)
  begin
    if (buf_wr_valid === 1'b1)
    begin
      bw_cnt++;
      bw_data = buf_wr_data;
    end
    if (conv_start === 1'b1)
    begin
      @(negedge pclk);
      samp_q.push_back(conv_data);
      n_conv++;
    end
  end

  // -----
  // Tasks
  // -----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // One bus transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  // Group mean, as the host would compute it
  function automatic logic [31:0] exp_avg(input int lg);
    int s = 0;
    repeat (1 << lg) s += samp_q.pop_front();
    return (s >>> lg) & 32'h0000_0FFF;
  endfunction : exp_avg
  task automatic fire;
    trig <= 1;
    tick(4);
    trig <= 0;
    tick(8);
  endtask : fire
  task automatic odr;
    odr_tick <= 1;
    @(posedge pclk);
    odr_tick <= 0;
    @(posedge pclk);
  endtask : odr
  // Poll for the flag, then read and clear it
  task automatic result_chk(input int lg, input string nm);
    int i;
    rd = 0;
    for (i = 0; i < 100 && rd[0] !== 1'b1; i++) apb(0, 8'h20, 0);
    apb(0, 8'h24, 0);
    chk(nm, rd, exp_avg(lg));
    apb(0, 8'h20, 0);
    chk("drdy_clr", rd[0], 0);
  endtask : result_chk
  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask : done
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // ---------
  // Sequence
  // ---------
  initial
  begin
    void'($urandom(77383));
    tick(5);
    presetn <= 1;
    tick(1);
    apb(0, 8'h18, 0);
    chk("cfg_rst", rd, 32'h0000_0001);
    v = 8'($urandom);
    apb(1, 8'h18, {24'h0, v});
    apb(0, 8'h18, 0);
    chk("cfg_rw", rd, {24'h0, v});
    apb(0, 8'h40, 0);
    chk("unmapped", err, 1);
    apb(1, 8'h18, 32'h0000_0001);
    done("registers");
    // Rate code changed only with the pin trigger off
    for (p = 0; p < 4; p++)
      for (c = 0; c < 16; c++)
      begin
        apb(1, 8'h1C, {26'h0, p[1:0], c[3:0]});
        apb(0, 8'h20, 0);
        chk("log2", rd[7:4], p == 0 ? 0 : (c > 12 ? 12 : c));
      end
    done("decimation");
    // One edge, burst of four
    apb(1, 8'h1C, 32'h0000_0022);
    apb(1, 8'h18, 32'h0000_0085);
    samp_q.delete();
    n_conv = 0;
    fire();
    apb(0, 8'h20, 0);
    chk("drdy_early", rd[0], 0);
    result_chk(2, "burst");
    chk("burst_n", n_conv, 4);
    done("burst");
    // Four edges per result
    apb(1, 8'h18, 32'h0000_0005);
    samp_q.delete();
    n_conv = 0;
    repeat (3) fire();
    apb(0, 8'h20, 0);
    chk("single_early", rd[0], 0);
    fire();
    result_chk(2, "single");
    chk("single_n", n_conv, 4);
    done("single");
    // Pin as output ignores edges
    apb(1, 8'h18, 32'h0000_0081);
    n_conv = 0;
    fire();
    chk("no_conv", n_conv, 0);
    // Buffer mode 01 sends result away, flag stays low
    apb(1, 8'h1C, 32'h0000_0060);
    samp_q.delete();
    bw_cnt = 0;
    odr();
    tick(20);
    chk("buf_n", bw_cnt, 1);
    chk("buf_data", bw_data, exp_avg(0));
    apb(0, 8'h20, 0);
    chk("buf_drdy", rd[0], 0);
    done("buffer");
    // Level output held until read
    apb(1, 8'h1C, 32'h0000_0020);
    apb(1, 8'h18, 32'h0000_0001);
    samp_q.delete();
    odr();
    tick(30);
    @(negedge pclk);
    chk("level", irq_pin_out, 1);
    @(posedge pclk);
    result_chk(0, "level_val");
    @(negedge pclk);
    chk("level_clr", irq_pin_out, 0);
    @(posedge pclk);
    // Pulse of fixed width
    apb(1, 8'h18, 32'h0000_0009);
    hi = 0;
    odr();
    repeat (40)
    begin
      @(negedge pclk);
      if (irq_pin_out === 1'b1)
        hi++;
    end
    chk("pulse_w", hi, PUL);
    @(posedge pclk);
    apb(0, 8'h24, 0);
    done("pin");
    // Strap forces level output despite pulse select
    boot_strap_mode_pin <= 1;
    tick(3);
    odr();
    tick(30);
    @(negedge pclk);
    chk("strap", irq_pin_out, 1);
    @(posedge pclk);
    apb(0, 8'h24, 0);
    boot_strap_mode_pin <= 0;
    tick(4);
    // Every wake enable combination, random events
    for (c = 0; c < 8; c++)
    begin
      apb(1, 8'h18, {24'h0, 1'b0, c[2:0], 4'h1});
      repeat (4)
      begin
        {evt_within_thr, evt_outside_thr, evt_orientation} <= 3'($urandom);
        @(negedge pclk);
        chk("wake", wake_event, |({evt_within_thr, evt_outside_thr, evt_orientation} & c[2:0]));
        @(posedge pclk);
      end
    end
    {evt_within_thr, evt_outside_thr, evt_orientation} <= 3'b000;
    // Other interrupt shares the pin
    other_irq <= 1;
    tick(3);
    @(negedge pclk);
    chk("other", irq_pin_out, 1);
    @(posedge pclk);
    other_irq <= 0;
    done("wake");
    // No start during the hold-off after a sleep change
    apb(1, 8'h18, 32'h0000_0001);
    n_conv = 0;
    sleep_mode <= 1;
    tick(2);
    repeat (GAP - 4)
    begin
      odr_tick <= 1;
      @(posedge pclk);
    end
    odr_tick <= 0;
    chk("gap", n_conv, 0);
    tick(4);
    odr();
    tick(8);
    chk("gap_end", n_conv, 1);
    done("gap");
    wrap_up();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    tick(20000);
    error_cnt++;
    wrap_up();
  end
endmodule : accel_acq_trigger_config_tb
